/* sst_pkg.sv */
// package for the synchronous slave serial transmitter
package sst_pkg;
  // -------------------------------------------------------------------------
  // register byte addresses
  // -------------------------------------------------------------------------
  localparam logic [7:0] ADDR_TX_STATUS_CONTROL = 8'h00;
  localparam logic [7:0] ADDR_RX_STATUS_CONTROL = 8'h04;
  localparam logic [7:0] ADDR_BAUD_CLOCK_CONTROL = 8'h08;
  localparam logic [7:0] ADDR_TX_DATA_BUFFER = 8'h0c;
  localparam logic [7:0] ADDR_INT_CONTROL = 8'h10;
  localparam logic [7:0] ADDR_BAUD_DIV_LOW = 8'h14;
  localparam logic [7:0] ADDR_BAUD_DIV_HIGH = 8'h18;
  // -------------------------------------------------------------------------
  // field positions
  // -------------------------------------------------------------------------
  // transmit status/control
  localparam int TXS_CLOCK_SOURCE = 7;
  localparam int TXS_NINE_BIT = 6;
  localparam int TXS_TX_ENABLE = 5;
  localparam int TXS_SYNC_SELECT = 4;
  localparam int TXS_SHIFT_EMPTY = 1;
  localparam int TXS_NINTH_DATA = 0;
  // receive status/control
  localparam int RXS_PORT_ENABLE = 7;
  localparam int RXS_SINGLE_RX = 5;
  localparam int RXS_CONT_RX = 4;
  // baud clock control
  localparam int BCC_CLOCK_POLARITY = 4;
  // interrupt control (own register)
  localparam int INT_GLOBAL_EN = 7;
  localparam int INT_PERIPH_EN = 6;
  localparam int INT_TX_EN = 4;
  localparam int INT_TX_FLAG = 0;
  // -------------------------------------------------------------------------
  // masks of implemented bits, reset values
  // -------------------------------------------------------------------------
  localparam logic [7:0] TXS_WMASK = 8'hf1;
  localparam logic [7:0] RXS_WMASK = 8'hb0;
  localparam logic [7:0] BCC_WMASK = 8'h10;
  localparam logic [7:0] INT_WMASK = 8'hd0;
  localparam logic [7:0] REG_RESET = 8'h00;
  localparam logic [1:0] HTRANS_NONSEQ = 2'b10;
  localparam logic [3:0] CHAR_BITS_8 = 4'd8;
  localparam logic [3:0] CHAR_BITS_9 = 4'd9;

  typedef enum logic [1:0] {TX_IDLE, TX_SHIFT} sst_tx_state_t;

  typedef struct packed {
    logic       sync_select;
    logic       clock_source_select;
    logic       serial_port_enable;
    logic       transmitter_enable;
    logic       transmit_nine_bit_enable;
    logic       clock_polarity_select;
    logic       receive_selected;
  } sst_cfg_t;
endpackage

/* sst_top.sv */
// synchronous slave serial transmitter with ahb-lite register slave
//
// Local design decisions: the placing of the registers and register access over AHB-Lite.
`timescale 1ns/10ps
`default_nettype none

// What this block does
// - sync select bit picks synchronous mode
// - clock source zero means external bit clock
// - both receive enables clear selects transmit
// - port enable bit gates whole port
// - slave transmit acts like master transmit
// - first word moves at once to shifter
// - second word waits; flag stays clear unless written during load_pulse
// - shifter done: load buffer and set flag on the same clock
// - flag with both enables wakes device
// - global enable too requests service call
// - nine bit enable sends ninth data bit
// - transmit only while transmitter enabled
// - writing buffer starts transmission when enabled
// - unimplemented bits read as zero
// - clock pin driver off in slave mode
// - data changes leading edge, one bit/cycle
module sst_top
  import sst_pkg::*;
(
  // system
  input  wire logic        hclk,
  input  wire logic        hresetn,
  // ahb-lite slave
  input  wire logic        hsel,
  input  wire logic [7:0]  haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  // shift clock pin, input only in slave mode
  input  wire logic        shift_clock_pin_in,
  output logic             shift_clock_pin_out,
  output logic             shift_clock_pin_oe,
  // serial data pin
  input  wire logic        serial_data_pin_in,
  output logic             serial_data_pin_out,
  output logic             serial_data_pin_oe,
  // wake and interrupt requests to the core
  output logic             wake_request,
  output logic             service_request
);

  // -------------------------------------------------------------------------
  // register bus
  // -------------------------------------------------------------------------
  logic [7:0] txs_r;
  logic [7:0] rxs_r;
  logic [7:0] bcc_r;
  logic [7:0] intc_r;
  logic [7:0] div_lo_r;
  logic [7:0] div_hi_r;
  logic       wr_pend_r;
  logic [7:0] wr_addr_r;
  logic       tx_flag_r;
  logic       shift_empty;
  logic       buf_full_r;
  logic [7:0] buf_data_r;
  logic       buf_ninth_r;

  wire logic  addr_phase = hsel && hready && (htrans == HTRANS_NONSEQ);
  wire logic  buf_write = wr_pend_r && (wr_addr_r == ADDR_TX_DATA_BUFFER);

  function automatic logic [7:0] reg_read(input logic [7:0] a);
    unique case (a)
      ADDR_TX_STATUS_CONTROL:  reg_read = (txs_r & TXS_WMASK) |
                                          {6'h00, shift_empty, 1'b0};
      ADDR_RX_STATUS_CONTROL:  reg_read = rxs_r & RXS_WMASK;
      ADDR_BAUD_CLOCK_CONTROL: reg_read = bcc_r & BCC_WMASK;
      ADDR_INT_CONTROL:        reg_read = (intc_r & INT_WMASK) | {7'h00, tx_flag_r};
      ADDR_BAUD_DIV_LOW:       reg_read = div_lo_r;
      ADDR_BAUD_DIV_HIGH:      reg_read = div_hi_r;
      default:                 reg_read = 8'h00; // buffer is write only
    endcase
  endfunction

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_r <= 1'b0;
      wr_addr_r <= 8'h00;
      hrdata    <= 32'h0000_0000;
    end else begin
      wr_pend_r <= addr_phase && hwrite;
      if (addr_phase) begin
        wr_addr_r <= haddr;
      end
      if (addr_phase && !hwrite) begin
        hrdata <= {24'h00_0000, reg_read(haddr)};
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end else begin
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      txs_r    <= REG_RESET;
      rxs_r    <= REG_RESET;
      bcc_r    <= REG_RESET;
      intc_r   <= REG_RESET;
      div_lo_r <= REG_RESET;
      div_hi_r <= REG_RESET;
    end else if (wr_pend_r) begin
      unique case (wr_addr_r)
        ADDR_TX_STATUS_CONTROL:  txs_r <= hwdata[7:0] & TXS_WMASK;
        ADDR_RX_STATUS_CONTROL:  rxs_r <= hwdata[7:0] & RXS_WMASK;
        ADDR_BAUD_CLOCK_CONTROL: bcc_r <= hwdata[7:0] & BCC_WMASK;
        ADDR_INT_CONTROL:        intc_r <= hwdata[7:0] & INT_WMASK;
        ADDR_BAUD_DIV_LOW:       div_lo_r <= hwdata[7:0];
        ADDR_BAUD_DIV_HIGH:      div_hi_r <= hwdata[7:0];
        default:                 ;
      endcase
    end
  end

  // -------------------------------------------------------------------------
  // mode decode
  // -------------------------------------------------------------------------
  sst_cfg_t cfg;
  assign cfg.sync_select              = txs_r[TXS_SYNC_SELECT];
  assign cfg.clock_source_select      = txs_r[TXS_CLOCK_SOURCE];
  assign cfg.serial_port_enable       = rxs_r[RXS_PORT_ENABLE];
  assign cfg.transmitter_enable       = txs_r[TXS_TX_ENABLE];
  assign cfg.transmit_nine_bit_enable = txs_r[TXS_NINE_BIT];
  assign cfg.clock_polarity_select    = bcc_r[BCC_CLOCK_POLARITY];
  assign cfg.receive_selected         = rxs_r[RXS_SINGLE_RX] | rxs_r[RXS_CONT_RX];

  // slave transmit needs sync, external clock, no receive, port on
  wire logic slave_mode = cfg.serial_port_enable && cfg.sync_select &&
                          !cfg.clock_source_select;
  wire logic tx_active  = slave_mode && !cfg.receive_selected &&
                          cfg.transmitter_enable;

  // -------------------------------------------------------------------------
  // clock pin synchroniser and edge detect
  // -------------------------------------------------------------------------
  logic ck_meta_r;
  logic ck_sync_r;
  logic ck_prev_r;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ck_meta_r <= 1'b0;
      ck_sync_r <= 1'b0;
      ck_prev_r <= 1'b0;
    end else begin
      ck_meta_r <= shift_clock_pin_in;
      ck_sync_r <= ck_meta_r;
      ck_prev_r <= ck_sync_r ^ cfg.clock_polarity_select;
    end
  end

  // polarity-corrected level; leading edge leaves the idle level
  wire logic ck_level   = ck_sync_r ^ cfg.clock_polarity_select;
  wire logic lead_edge  = ck_level && !ck_prev_r;
  wire logic trail_edge = !ck_level && ck_prev_r;

  // -------------------------------------------------------------------------
  // transmit buffer and shift register
  // -------------------------------------------------------------------------
  sst_tx_state_t state_r;
  logic [8:0]    shreg_r;
  logic [3:0]    bits_left_r;
  logic [3:0]    char_len_r;
  logic          data_out_r;
  logic          load_pulse;

  // the shifter takes the buffer when idle, or when the last bit's trailing edge ends
  wire logic last_done = (state_r == TX_SHIFT) && trail_edge && (bits_left_r == 4'd1);
  assign load_pulse    = tx_active && buf_full_r &&
                         ((state_r == TX_IDLE) || last_done);
  assign shift_empty   = (state_r == TX_IDLE);

  // buffer holds a second word while the first shifts out
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      buf_full_r  <= 1'b0;
      buf_data_r  <= 8'h00;
      buf_ninth_r <= 1'b0;
    end else begin
      if (buf_write) begin
        buf_full_r  <= 1'b1;
        buf_data_r  <= hwdata[7:0];
        buf_ninth_r <= txs_r[TXS_NINTH_DATA];
      end else if (load_pulse || !slave_mode) begin
        buf_full_r <= 1'b0;
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_r     <= TX_IDLE;
      shreg_r     <= 9'h000;
      bits_left_r <= 4'd0;
      char_len_r  <= 4'd0;
      data_out_r  <= 1'b0;
    end else if (!tx_active) begin
      state_r     <= TX_IDLE;
      bits_left_r <= 4'd0;
    end else if (load_pulse) begin
      state_r     <= TX_SHIFT;
      shreg_r     <= {buf_ninth_r, buf_data_r};
      char_len_r  <= cfg.transmit_nine_bit_enable ? CHAR_BITS_9 : CHAR_BITS_8;
      bits_left_r <= cfg.transmit_nine_bit_enable ? CHAR_BITS_9 : CHAR_BITS_8;
      data_out_r  <= buf_data_r[0];
    end else begin
      unique case (state_r)
        TX_IDLE: ;
        TX_SHIFT: begin
          if (lead_edge && (bits_left_r != char_len_r)) begin
            data_out_r <= shreg_r[0];
          end
          if (trail_edge) begin
            shreg_r     <= {1'b0, shreg_r[8:1]};
            bits_left_r <= bits_left_r - 4'd1;
            if (bits_left_r == 4'd1) begin
              state_r <= TX_IDLE;
            end
          end
        end
        default: state_r <= TX_IDLE;
      endcase
    end
  end

  // -------------------------------------------------------------------------
  // transmit flag, wake and service requests
  // -------------------------------------------------------------------------
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      tx_flag_r <= 1'b0;
    end else if (load_pulse) begin
      tx_flag_r <= 1'b1;
    end else if (buf_write) begin
      tx_flag_r <= 1'b0;
    end else if (!tx_active) begin
      tx_flag_r <= !buf_full_r;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wake_request        <= 1'b0;
      service_request     <= 1'b0;
      shift_clock_pin_out <= 1'b0;
      shift_clock_pin_oe  <= 1'b0;
      serial_data_pin_out <= 1'b0;
      serial_data_pin_oe  <= 1'b0;
    end else begin
      wake_request    <= tx_flag_r && intc_r[INT_PERIPH_EN] && intc_r[INT_TX_EN];
      service_request <= tx_flag_r && intc_r[INT_PERIPH_EN] && intc_r[INT_TX_EN] &&
                         intc_r[INT_GLOBAL_EN];
      shift_clock_pin_out <= 1'b0;
      shift_clock_pin_oe  <= 1'b0;
      serial_data_pin_out <= data_out_r;
      serial_data_pin_oe  <= tx_active;
    end
  end

  // -------------------------------------------------------------------------
  // checks
  // -------------------------------------------------------------------------
  sequence buf_wr_s;
    buf_write && tx_active && (state_r == TX_IDLE);
  endsequence

  first_load_a: assert property (@(posedge hclk) disable iff (!hresetn)
    buf_wr_s |=> load_pulse ##1 (state_r == TX_SHIFT))
    else $error("idle shifter did not take buffered word");

  flag_clear_a: assert property (@(posedge hclk) disable iff (!hresetn)
    buf_write && !load_pulse |=> !tx_flag_r)
    else $error("buffer write did not clear transmit flag");

  flag_set_a: assert property (@(posedge hclk) disable iff (!hresetn)
    load_pulse |=> tx_flag_r && !buf_full_r)
    else $error("flag not set after shifter load");

  wake_gate_a: assert property (@(posedge hclk) disable iff (!hresetn)
    $rose(tx_flag_r) && intc_r[INT_PERIPH_EN] && intc_r[INT_TX_EN] &&
    $stable(intc_r) |=> wake_request)
    else $error("wake request missing");

  service_gate_a: assert property (@(posedge hclk) disable iff (!hresetn)
    service_request |-> $past(intc_r[INT_GLOBAL_EN]) && wake_request)
    else $error("service request without global enable");

  clock_driver_a: assert property (@(posedge hclk) disable iff (!hresetn)
    !shift_clock_pin_oe)
    else $error("clock pin driven in slave mode");

  tx_gate_a: assert property (@(posedge hclk) disable iff (!hresetn)
    !tx_active |=> state_r == TX_IDLE)
    else $error("shifter runs while transmitter off");

  bit_count_a: assert property (@(posedge hclk) disable iff (!hresetn)
    (state_r == TX_SHIFT) && trail_edge && tx_active && !load_pulse |=>
    bits_left_r == $past(bits_left_r) - 4'd1)
    else $error("bit count not stepped on trailing edge");

  nine_bit_a: assert property (@(posedge hclk) disable iff (!hresetn)
    load_pulse && cfg.transmit_nine_bit_enable |=> char_len_r == CHAR_BITS_9)
    else $error("nine bit length not selected");

  // a waiting word follows the last bit with no idle gap, or the master loses a bit
  hand_over_a: assert property (@(posedge hclk) disable iff (!hresetn)
    last_done && buf_full_r && tx_active |=> (state_r == TX_SHIFT) &&
    (bits_left_r == char_len_r) && tx_flag_r)
    else $error("waiting word not handed to shifter");

  lsb_first_a: assert property (@(posedge hclk) disable iff (!hresetn)
    load_pulse |=> data_out_r == shreg_r[0])
    else $error("first bit out is not the lsb");

  read_zero_a: assert property (@(posedge hclk) disable iff (!hresetn)
    hrdata[31:8] == 24'h00_0000)
    else $error("upper read bits not zero");

endmodule

`default_nettype wire

/* sst_master_model.sv */
// external synchronous master that clocks characters out of the slave
`timescale 1ns/10ps
`default_nettype none
module sst_master_model (
  // link
  input  wire logic data_in,
  output var  logic clk_out
);
  logic pol;

  initial begin
    pol     = 1'b0;
    clk_out = 1'b0;
  end

  // --------------------------------------------------------------------------
  // clock stands at its idle level between frames
  // --------------------------------------------------------------------------
  task automatic set_idle(input logic p);
    pol     = p;
    clk_out <= p;
  endtask

  // odd start offset keeps link edges away from the system clock edges
  task automatic clock_char(input int nbits, output logic [8:0] got);
    got = 9'h000;
    #37;
    for (int i = 0; i < nbits; i++) begin
      #400 clk_out = ~pol;
      #400 got[i] = data_in;
      clk_out = pol;
    end
    #400;
  endtask
endmodule
`default_nettype wire

/* testbench.sv */
// self-checking bench for the synchronous slave serial transmitter
`timescale 1ns/10ps
`default_nettype none
module testbench
  import sst_pkg::*;
;
  logic        hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp;
  logic [7:0]  haddr;
  logic [1:0]  htrans;
  logic [31:0] hwdata, hrdata, rdv;
  logic        sck, sck_out, sck_oe, sdo, sdo_oe, wake, svc;
  logic        sdo_line;
  logic [8:0]  got;
  int          num_errors = 0;
  int          checks_done = 0;

  assign hready = hreadyout;
  // a released data line shows the inverse of its last value
  assign sdo_line = sdo_oe ? sdo : ~sdo;

  sst_top dut_u (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'b010), .hwdata(hwdata), .hready(hready),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .shift_clock_pin_in(sck),
    .shift_clock_pin_out(sck_out), .shift_clock_pin_oe(sck_oe), .serial_data_pin_in(1'b0),
    .serial_data_pin_out(sdo), .serial_data_pin_oe(sdo_oe), .wake_request(wake),
    .service_request(svc));

  sst_master_model master_u (.data_in(sdo_line), .clk_out(sck));

  initial begin
    hclk = 1'b0;
    forever #50 hclk = ~hclk;
  end

  // --------------------------------------------------------------------------
  // shared tasks
  // --------------------------------------------------------------------------
  task automatic report_and_stop;
    if (num_errors == 0 && checks_done > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  task automatic check(input logic [31:0] g, input logic [31:0] e, input string what);
    checks_done++;
    if (g !== e) begin
      num_errors++;
      $display("[ERR] %0t %s", $time, what);
    end
  endtask

  task automatic wait_ready;
    int n;
    n = 0;
    do begin
      @(posedge hclk);
      n++;
    end while (hready !== 1'b1 && n < 50);
    if (hready !== 1'b1) begin
      num_errors++;
      $display("[ERR] %0t bus wait timed out", $time);
      report_and_stop();
    end
  endtask

  // one single transfer; read data taken at the edge that ends the data phase
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    hsel   <= 1'b1;
    haddr  <= a;
    htrans <= HTRANS_NONSEQ;
    hwrite <= wr;
    wait_ready();
    hsel   <= 1'b0;
    htrans <= 2'b00;
    hwdata <= wd;
    wait_ready();
    rdv = hrdata;
    check({31'h0, hresp}, 32'h0, "bus response not okay");
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e,
                        input string what);
    bus(1'b0, a, 32'h0);
    check(rdv & m, e, what);
  endtask

  task automatic shift(input int n);
    master_u.clock_char(n, got);
    @(posedge hclk);
  endtask

  // --------------------------------------------------------------------------
  // scenarios
  // --------------------------------------------------------------------------
  task automatic test_regs;
    logic [7:0] ra [8] = '{8'h00, 8'h04, 8'h08, 8'h10, 8'h14, 8'h18, 8'h0c, 8'h1c};
    logic [7:0] rm [8] = '{8'hfd, 8'hff, 8'hff, 8'hfe, 8'hff, 8'hff, 8'hff, 8'hff};
    logic [7:0] re [8] = '{8'hf1, 8'hb0, 8'h10, 8'hd0, 8'hff, 8'hff, 8'h00, 8'h00};
    for (int i = 0; i < 8; i++) begin
      rd_chk(ra[i], {24'hffffff, rm[i]}, 32'h0, "reset value");
      if (i < 6 || i == 7) bus(1'b1, ra[i], 32'hffffffff);
      rd_chk(ra[i], {24'hffffff, rm[i]}, {24'h0, re[i]}, "readback");
    end
    for (int i = 0; i < 6; i++) bus(1'b1, ra[i], 32'h0);
  endtask

  task automatic test_modes;
    logic [7:0] tx [7] = '{8'h30, 8'h20, 8'hb0, 8'h30, 8'h30, 8'h10, 8'h30};
    logic [7:0] rx [7] = '{8'h00, 8'h80, 8'h80, 8'ha0, 8'h90, 8'h80, 8'h80};
    for (int i = 0; i < 7; i++) begin
      bus(1'b1, ADDR_RX_STATUS_CONTROL, {24'h0, rx[i]});
      bus(1'b1, ADDR_TX_STATUS_CONTROL, {24'h0, tx[i]});
      repeat (2) @(posedge hclk);
      check({31'h0, sdo_oe}, {31'h0, i == 6}, "data driver enable");
      check({31'h0, sck_oe}, 32'h0, "clock driver enabled");
      check({31'h0, sck_out}, 32'h0, "clock pin output not low");
    end
  endtask

  task automatic test_pair;
    bus(1'b1, ADDR_INT_CONTROL, 32'hd0);
    bus(1'b1, ADDR_TX_DATA_BUFFER, 32'ha5);
    bus(1'b1, ADDR_TX_DATA_BUFFER, 32'h3c);
    rd_chk(ADDR_INT_CONTROL, 32'h1, 32'h0, "flag set with word waiting");
    check({31'h0, wake}, 32'h0, "early wake");
    check({31'h0, sdo}, 32'h1, "first bit not placed");
    shift(8);
    check({23'h0, got}, 32'ha5, "first character");
    rd_chk(ADDR_INT_CONTROL, 32'h1, 32'h1, "flag after hand-over");
    check({31'h0, wake}, 32'h1, "no wake");
    check({31'h0, svc}, 32'h1, "no service call");
    shift(8);
    check({23'h0, got}, 32'h3c, "second character");
    bus(1'b1, ADDR_INT_CONTROL, 32'h50);
    repeat (2) @(posedge hclk);
    check({31'h0, svc}, 32'h0, "service without global enable");
    check({31'h0, wake}, 32'h1, "wake lost");
    bus(1'b1, ADDR_INT_CONTROL, 32'h40);
    repeat (2) @(posedge hclk);
    check({31'h0, wake}, 32'h0, "wake without tx enable");
  endtask

  // polarity is changed with the path off so the idle flip is no clock edge
  task automatic test_nine;
    bus(1'b1, ADDR_TX_STATUS_CONTROL, 32'h0);
    master_u.set_idle(1'b1);
    bus(1'b1, ADDR_BAUD_CLOCK_CONTROL, 32'h10);
    bus(1'b1, ADDR_TX_STATUS_CONTROL, 32'h71);
    bus(1'b1, ADDR_TX_DATA_BUFFER, 32'h5a);
    shift(9);
    check({23'h0, got}, 32'h15a, "nine bit character");
  endtask

  initial begin
    hresetn = 1'b0;
    hsel    = 1'b0;
    haddr   = 8'h00;
    htrans  = 2'b00;
    hwrite  = 1'b0;
    hwdata  = 32'h0;
    repeat (12) @(posedge hclk);
    hresetn <= 1'b1;
    test_regs();
    test_modes();
    test_pair();
    test_nine();
    report_and_stop();
  end
endmodule
`default_nettype wire
